// [verilog/uart_pkg.sv]
// Shared constants, types and register map for the dual serial port block
package uart_pkg;
   localparam int CLK_HZ   = 10_000_000;
   localparam int BAUD_MIN = 1_200;
   localparam int BAUD_MAX = 921_600;
   localparam int MBAUD_HI = 1_000_000;
   localparam int MBAUD_LO = 250_000;
   localparam int BAUD_RST = 9_600;
   localparam logic [15:0] DIV_MBAUD_HI = 16'(CLK_HZ / MBAUD_HI);
   localparam logic [15:0] DIV_MBAUD_LO = 16'(CLK_HZ / MBAUD_LO);
   localparam logic [15:0] DIV_SLOWEST  = 16'(CLK_HZ / BAUD_MIN);
   localparam logic [15:0] DIV_FASTEST  = 16'(CLK_HZ / BAUD_MAX);
   localparam logic [15:0] DIV_RESET    = 16'(CLK_HZ / BAUD_RST);
   localparam int NPORT      = 2;
   localparam int FIFO_DEPTH = 64;
   localparam int PTR_W      = 6;
   localparam logic [PTR_W:0] FIFO_FULL = 7'h40;
   // Register map: byte address = port * PORT_STRIDE + index * 4
   localparam int ADDR_W        = 8;
   localparam int PORT_SEL_BIT  = 5;
   localparam logic [2:0] REG_DATA = 3'h0;
   localparam logic [2:0] REG_LINE = 3'h1;
   localparam logic [2:0] REG_DIV  = 3'h2;
   localparam logic [2:0] REG_STAT = 3'h3;
   localparam logic [7:0] PORT_STRIDE = 8'h20;
   // Line control fields
   localparam int LC_LEN_LSB  = 0;
   localparam int LC_STOP2    = 2;
   localparam int LC_PAR_EN   = 3;
   localparam int LC_PAR_EVEN = 4;
   localparam int LC_LOOP     = 5;
   localparam int LC_RTS      = 6;
   localparam int LC_MBAUD    = 7;
   localparam logic [7:0] LC_RESET = 8'h03;
   // Status fields
   localparam int ST_RX_AVAIL = 0;
   localparam int ST_TX_FULL  = 1;
   localparam int ST_TX_IDLE  = 2;
   localparam int ST_CTS      = 3;
   localparam int ST_ERR_LSB  = 4;
   localparam int ST_STRAP    = 7;
   localparam int ERR_PAR     = 0;
   localparam int ERR_FRM     = 1;
   localparam int ERR_OVR     = 2;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic              awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic              wvalid;
      logic [31:0]       wdata;
      logic [3:0]        wstrb;
      logic              bready;
      logic              arvalid;
      logic [ADDR_W-1:0] araddr;
      logic              rready;
   } axil_req_s;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } axil_rsp_s;

   typedef enum logic [2:0] {
      TX_IDLE, TX_FETCH, TX_START, TX_DATA, TX_PARITY, TX_STOP
   } tx_state_e;

   typedef enum logic [2:0] {
      RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP
   } rx_state_e;
endpackage

// [verilog/fifo_ram.sv]
// Byte buffer memory with registered read data
`timescale 1ns/1ns
module fifo_ram (
   input  wire logic                       sys_clk, // System clock
   input  wire logic                       we,      // Write enable
   input  wire logic [uart_pkg::PTR_W-1:0] waddr,   // Write address
   input  wire logic [7:0]                 wdata,   // Write data
   input  wire logic [uart_pkg::PTR_W-1:0] raddr,   // Read address
   output      logic [7:0]                 rdata    // Registered read data
);
   import uart_pkg::*;

   logic [7:0] mem [FIFO_DEPTH];

   always_ff @(posedge sys_clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule // fifo_ram

// [verilog/dual_uart.sv]
// Two serial ports with modem handshake, behind an AXI4-Lite slave
//
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ns
module dual_uart (
   input  wire logic                sys_clk,                        // Clock
   input  wire logic                resetn,                         // Reset
   input  wire uart_pkg::axil_req_s axi_req,                        // Bus in
   output      uart_pkg::axil_rsp_s axi_rsp,                        // Bus out
   input  wire logic                megabaud_strap,                 // Strap
   input  wire logic                fast_port_serial_in,            // Rx
   output      logic                fast_port_serial_out,           // Tx
   input  wire logic                fast_port_clear_to_send_n,      // CTS
   output      logic                fast_port_request_to_send_n,    // RTS
   input  wire logic                console_port_serial_in,         // Rx
   output      logic                console_port_serial_out,        // Tx
   input  wire logic                console_port_clear_to_send_n,   // CTS
   output      logic                console_port_request_to_send_n  // RTS
);
   import uart_pkg::*;

   // Per-port state shared between bus logic and serial engines
   logic [PTR_W:0]   tx_wp_q  [NPORT];
   logic [PTR_W:0]   tx_rp_q  [NPORT];
   logic [PTR_W:0]   rx_wp_q  [NPORT];
   logic [PTR_W:0]   rx_rp_q  [NPORT];
   logic [7:0]       lc_q     [NPORT];
   logic [15:0]      div_q    [NPORT];
   logic [2:0]       err_q    [NPORT];
   logic [2:0]       err_clr_q[NPORT];
   logic [7:0]       tx_rdata [NPORT];
   logic [7:0]       rx_rdata [NPORT];
   logic             tx_we    [NPORT];
   logic             rx_we    [NPORT];
   logic [7:0]       rx_wdata [NPORT];
   logic             tx_idle  [NPORT];
   logic             cts_n_s  [NPORT];
   logic [NPORT-1:0] rx_pin;
   logic [NPORT-1:0] cts_pin_n;
   logic [NPORT-1:0] tx_pin;
   logic [NPORT-1:0] rts_pin_n;

   // Strap capture, once after reset release
   logic strap_m_q;
   logic strap_s_q;
   logic strap_q;
   logic strap_done_q;

   // Bus slave state
   logic              aw_held_q;
   logic              w_held_q;
   logic [ADDR_W-1:0] aw_addr_q;
   logic [31:0]       w_data_q;
   logic [3:0]        w_strb_q;
   logic              bvalid_q;
   logic [1:0]        bresp_q;
   logic              rd_pend_q;
   logic [ADDR_W-1:0] rd_addr_q;
   logic              rvalid_q;
   logic [31:0]       rdata_q;
   logic [1:0]        rresp_q;
   logic              wr_go;
   logic              wr_port;
   logic [2:0]        wr_idx;
   logic              wr_ok;
   logic              rd_port;
   logic [2:0]        rd_idx;
   logic              rd_ok;

   assign rx_pin    = {console_port_serial_in, fast_port_serial_in};
   assign cts_pin_n = {console_port_clear_to_send_n,
                       fast_port_clear_to_send_n};
   assign fast_port_serial_out           = tx_pin[0];
   assign console_port_serial_out        = tx_pin[1];
   assign fast_port_request_to_send_n    = rts_pin_n[0];
   assign console_port_request_to_send_n = rts_pin_n[1];

   always_ff @(posedge sys_clk) begin
      strap_m_q <= megabaud_strap;
      strap_s_q <= strap_m_q;
   end

   // Unstrapped pin is pulled up, so the default capture is the fast rate
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         strap_q      <= 1'b1;
         strap_done_q <= 1'b0;
      end else if (!strap_done_q) begin
         strap_q      <= strap_s_q;
         strap_done_q <= 1'b1;
      end
   end

   // Write and read address decode
   assign wr_port = aw_addr_q[PORT_SEL_BIT];
   assign wr_idx  = aw_addr_q[4:2];
   assign wr_ok   = (aw_addr_q[7:6] == 2'h0) && (wr_idx <= REG_STAT);
   assign wr_go   = aw_held_q && w_held_q && !bvalid_q;
   assign rd_port = rd_addr_q[PORT_SEL_BIT];
   assign rd_idx  = rd_addr_q[4:2];
   assign rd_ok   = (rd_addr_q[7:6] == 2'h0) && (rd_idx <= REG_STAT);

   always_comb begin
      axi_rsp         = '0;
      axi_rsp.awready = !aw_held_q && !bvalid_q;
      axi_rsp.wready  = !w_held_q && !bvalid_q;
      axi_rsp.bvalid  = bvalid_q;
      axi_rsp.bresp   = bresp_q;
      axi_rsp.arready = !rd_pend_q && !rvalid_q;
      axi_rsp.rvalid  = rvalid_q;
      axi_rsp.rdata   = rdata_q;
      axi_rsp.rresp   = rresp_q;
   end

   // Write channel: address and data taken in either order
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         aw_held_q <= 1'b0;
         w_held_q  <= 1'b0;
         aw_addr_q <= '0;
         w_data_q  <= '0;
         w_strb_q  <= '0;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
      end else begin
         if (axi_req.awvalid && axi_rsp.awready) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= axi_req.awaddr;
         end
         if (axi_req.wvalid && axi_rsp.wready) begin
            w_held_q <= 1'b1;
            w_data_q <= axi_req.wdata;
            w_strb_q <= axi_req.wstrb;
         end
         if (wr_go) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_q && axi_req.bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // Read channel: answer two cycles after the address is taken
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         rd_pend_q <= 1'b0;
         rd_addr_q <= '0;
         rvalid_q  <= 1'b0;
         rdata_q   <= '0;
         rresp_q   <= RESP_OKAY;
      end else begin
         if (axi_req.arvalid && axi_rsp.arready) begin
            rd_pend_q <= 1'b1;
            rd_addr_q <= axi_req.araddr;
         end else if (rd_pend_q) begin
            rd_pend_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rresp_q   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            rdata_q   <= '0;
            if (rd_ok) begin
               unique case (rd_idx)
                  REG_DATA: rdata_q[7:0]  <= rx_rdata[rd_port];
                  REG_LINE: rdata_q[7:0]  <= lc_q[rd_port];
                  REG_DIV:  rdata_q[15:0] <= div_q[rd_port];
                  REG_STAT: begin
                     rdata_q[ST_RX_AVAIL] <=
                        rx_wp_q[rd_port] != rx_rp_q[rd_port];
                     rdata_q[ST_TX_FULL] <=
                        (tx_wp_q[rd_port] - tx_rp_q[rd_port]) == FIFO_FULL;
                     rdata_q[ST_TX_IDLE] <= tx_idle[rd_port];
                     rdata_q[ST_CTS] <= !cts_n_s[rd_port];
                     rdata_q[ST_ERR_LSB +: 3] <= err_q[rd_port];
                     rdata_q[ST_STRAP] <= strap_q;
                  end
                  default: rdata_q <= '0;
               endcase
            end
         end else if (rvalid_q && axi_req.rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   // Register writes, buffer pointers owned by the bus side
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         for (int p = 0; p < NPORT; p++) begin
            lc_q[p]      <= LC_RESET;
            div_q[p]     <= DIV_RESET;
            tx_wp_q[p]   <= '0;
            rx_rp_q[p]   <= '0;
            err_clr_q[p] <= '0;
         end
      end else begin
         for (int p = 0; p < NPORT; p++) begin
            err_clr_q[p] <= '0;
            if (tx_we[p]) begin
               tx_wp_q[p] <= tx_wp_q[p] + 7'h01;
            end
            if (rd_pend_q && rd_ok && rd_idx == REG_DATA &&
                rd_port == p[0] && rx_wp_q[p] != rx_rp_q[p]) begin
               rx_rp_q[p] <= rx_rp_q[p] + 7'h01;
            end
         end
         if (wr_go && wr_ok) begin
            if (wr_idx == REG_LINE && w_strb_q[0]) begin
               lc_q[wr_port] <= w_data_q[7:0];
            end
            if (wr_idx == REG_DIV) begin
               if (w_strb_q[0]) div_q[wr_port][7:0] <= w_data_q[7:0];
               if (w_strb_q[1]) div_q[wr_port][15:8] <= w_data_q[15:8];
            end
            if (wr_idx == REG_STAT && w_strb_q[0]) begin
               err_clr_q[wr_port] <= w_data_q[ST_ERR_LSB +: 3];
            end
         end
      end
   end

   // Same engine for both ports
   for (genvar p = 0; p < NPORT; p++) begin : g_port
      tx_state_e  tx_st_q;
      rx_state_e  rx_st_q;
      logic [15:0] eff_div;
      logic [15:0] tx_cnt_q;
      logic [15:0] rx_cnt_q;
      logic [2:0]  tx_bit_q;
      logic [2:0]  rx_bit_q;
      logic [2:0]  last_bit;
      logic [7:0]  tx_sh_q;
      logic [7:0]  rx_sh_q;
      logic        tx_par_q;
      logic        rx_par_q;
      logic        tx_stop2_q;
      logic        txd_q;
      logic        rx_m_q;
      logic        rx_s_q;
      logic        cts_m_q;
      logic        cts_s_q;
      logic        rx_prev_q;
      logic        rx_line;
      logic        loop;
      logic        rx_full;
      logic [2:0]  err_set;

      assign loop     = lc_q[p][LC_LOOP];
      assign last_bit = 3'(lc_q[p][LC_LEN_LSB +: 2]) + 3'h4;
      assign rx_full  = (rx_wp_q[p] - rx_rp_q[p]) == FIFO_FULL;
      assign tx_we[p] = wr_go && wr_ok && wr_port == 1'(p) &&
                        wr_idx == REG_DATA && w_strb_q[0] &&
                        (tx_wp_q[p] - tx_rp_q[p]) != FIFO_FULL;
      assign tx_idle[p] = tx_st_q == TX_IDLE && tx_wp_q[p] == tx_rp_q[p];
      assign cts_n_s[p] = cts_s_q;

      always_comb begin
         if (lc_q[p][LC_MBAUD]) begin
            eff_div = strap_q ? DIV_MBAUD_HI : DIV_MBAUD_LO;
         end else if (div_q[p] == 16'h0000) begin
            eff_div = 16'h0001;
         end else begin
            eff_div = div_q[p];
         end
      end

      // Pins: idle high, loop holds both outputs inactive
      assign tx_pin[p]    = loop ? 1'b1 : txd_q;
      assign rts_pin_n[p] = loop ? 1'b1 : !lc_q[p][LC_RTS];
      assign rx_line      = loop ? txd_q : rx_s_q;

      always_ff @(posedge sys_clk) begin
         rx_m_q  <= rx_pin[p];
         rx_s_q  <= rx_m_q;
         cts_m_q <= cts_pin_n[p];
         cts_s_q <= cts_m_q;
      end

      fifo_ram u_tx_ram (
         .sys_clk (sys_clk),
         .we      (tx_we[p]),
         .waddr   (tx_wp_q[p][PTR_W-1:0]),
         .wdata   (w_data_q[7:0]),
         .raddr   (tx_rp_q[p][PTR_W-1:0]),
         .rdata   (tx_rdata[p])
      );

      fifo_ram u_rx_ram (
         .sys_clk (sys_clk),
         .we      (rx_we[p]),
         .waddr   (rx_wp_q[p][PTR_W-1:0]),
         .wdata   (rx_wdata[p]),
         .raddr   (rx_rp_q[p][PTR_W-1:0]),
         .rdata   (rx_rdata[p])
      );

      // Transmitter
      always_ff @(posedge sys_clk) begin
         if (!resetn) begin
            tx_st_q    <= TX_IDLE;
            txd_q      <= 1'b1;
            tx_cnt_q   <= '0;
            tx_bit_q   <= '0;
            tx_sh_q    <= '0;
            tx_par_q   <= 1'b0;
            tx_stop2_q <= 1'b0;
            tx_rp_q[p] <= '0;
         end else begin
            if (tx_cnt_q != 16'h0000) begin
               tx_cnt_q <= tx_cnt_q - 16'h0001;
            end
            unique case (tx_st_q)
               TX_IDLE: begin
                  if (tx_wp_q[p] != tx_rp_q[p]) tx_st_q <= TX_FETCH;
               end
               TX_FETCH: begin
                  tx_sh_q    <= tx_rdata[p];
                  tx_rp_q[p] <= tx_rp_q[p] + 7'h01;
                  txd_q      <= 1'b0;
                  tx_cnt_q   <= eff_div - 16'h0001;
                  tx_st_q    <= TX_START;
               end
               TX_START: begin
                  if (tx_cnt_q == 16'h0000) begin
                     txd_q    <= tx_sh_q[0];
                     tx_par_q <= tx_sh_q[0];
                     tx_sh_q  <= tx_sh_q >> 1;
                     tx_bit_q <= '0;
                     tx_cnt_q <= eff_div - 16'h0001;
                     tx_st_q  <= TX_DATA;
                  end
               end
               TX_DATA: begin
                  if (tx_cnt_q == 16'h0000) begin
                     tx_cnt_q <= eff_div - 16'h0001;
                     if (tx_bit_q == last_bit) begin
                        tx_stop2_q <= 1'b0;
                        if (lc_q[p][LC_PAR_EN]) begin
                           txd_q   <= lc_q[p][LC_PAR_EVEN] ? tx_par_q
                                                           : !tx_par_q;
                           tx_st_q <= TX_PARITY;
                        end else begin
                           txd_q   <= 1'b1;
                           tx_st_q <= TX_STOP;
                        end
                     end else begin
                        txd_q    <= tx_sh_q[0];
                        tx_par_q <= tx_par_q ^ tx_sh_q[0];
                        tx_sh_q  <= tx_sh_q >> 1;
                        tx_bit_q <= tx_bit_q + 3'h1;
                     end
                  end
               end
               TX_PARITY: begin
                  if (tx_cnt_q == 16'h0000) begin
                     txd_q    <= 1'b1;
                     tx_cnt_q <= eff_div - 16'h0001;
                     tx_st_q  <= TX_STOP;
                  end
               end
               TX_STOP: begin
                  if (tx_cnt_q == 16'h0000) begin
                     if (lc_q[p][LC_STOP2] && !tx_stop2_q) begin
                        tx_stop2_q <= 1'b1;
                        tx_cnt_q   <= eff_div - 16'h0001;
                     end else begin
                        tx_st_q <= TX_IDLE;
                     end
                  end
               end
            endcase
         end
      end

      // Receiver pushes a character at the middle of its first stop bit
      assign rx_we[p]    = rx_st_q == RX_STOP && rx_cnt_q == 16'h0000 &&
                           !rx_full;
      assign rx_wdata[p] = rx_sh_q >> (3'h3 - lc_q[p][LC_LEN_LSB +: 2]);

      always_comb begin
         err_set = '0;
         if (rx_st_q == RX_STOP && rx_cnt_q == 16'h0000) begin
            err_set[ERR_FRM] = !rx_line;
            err_set[ERR_OVR] = rx_full;
         end
         if (rx_st_q == RX_PARITY && rx_cnt_q == 16'h0000) begin
            err_set[ERR_PAR] = rx_line != (lc_q[p][LC_PAR_EVEN] ? rx_par_q
                                                               : !rx_par_q);
         end
      end

      always_ff @(posedge sys_clk) begin
         if (!resetn) begin
            rx_st_q    <= RX_IDLE;
            rx_cnt_q   <= '0;
            rx_bit_q   <= '0;
            rx_sh_q    <= '0;
            rx_par_q   <= 1'b0;
            rx_prev_q  <= 1'b1;
            rx_wp_q[p] <= '0;
            err_q[p]   <= '0;
         end else begin
            rx_prev_q <= rx_line;
            err_q[p]  <= (err_q[p] & ~err_clr_q[p]) | err_set;     // set wins
            if (rx_we[p]) begin
               rx_wp_q[p] <= rx_wp_q[p] + 7'h01;
            end
            if (rx_cnt_q != 16'h0000) begin
               rx_cnt_q <= rx_cnt_q - 16'h0001;
            end
            unique case (rx_st_q)
               RX_IDLE: begin
                  if (rx_prev_q && !rx_line) begin
                     rx_cnt_q <= eff_div >> 1;
                     rx_st_q  <= RX_START;
                  end
               end
               RX_START: begin
                  if (rx_cnt_q == 16'h0000) begin
                     rx_cnt_q <= eff_div - 16'h0001;
                     rx_bit_q <= '0;
                     rx_par_q <= 1'b0;
                     rx_st_q  <= rx_line ? RX_IDLE : RX_DATA;
                  end
               end
               RX_DATA: begin
                  if (rx_cnt_q == 16'h0000) begin
                     rx_sh_q  <= {rx_line, rx_sh_q[7:1]};
                     rx_par_q <= rx_par_q ^ rx_line;
                     rx_cnt_q <= eff_div - 16'h0001;
                     rx_bit_q <= rx_bit_q + 3'h1;
                     if (rx_bit_q == last_bit) begin
                        rx_st_q <= lc_q[p][LC_PAR_EN] ? RX_PARITY : RX_STOP;
                     end
                  end
               end
               RX_PARITY: begin
                  if (rx_cnt_q == 16'h0000) begin
                     rx_cnt_q <= eff_div - 16'h0001;
                     rx_st_q  <= RX_STOP;
                  end
               end
               RX_STOP: begin
                  if (rx_cnt_q == 16'h0000) rx_st_q <= RX_IDLE;
               end
            endcase
         end
      end
   end
endmodule // dual_uart

// [testbench/dual_uart_asserts.sv]
// Concurrent checks on the dual serial port pins and bus
`timescale 1ns/1ns
module dual_uart_asserts (
   input wire logic                sys_clk,                       // Clock
   input wire logic                resetn,                        // Reset
   input wire uart_pkg::axil_req_s axi_req,                       // Bus in
   input wire uart_pkg::axil_rsp_s axi_rsp,                       // Bus out
   input wire logic                fast_port_serial_out,          // Tx
   input wire logic                fast_port_request_to_send_n,   // RTS
   input wire logic                console_port_serial_out,       // Tx
   input wire logic                console_port_request_to_send_n // RTS
);
   import uart_pkg::*;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);
   tx_reset_a: assert property ($rose(resetn) |->
      (fast_port_serial_out && console_port_serial_out) [*2])
      else $error("serial out not marking after reset");
   rts_reset_a: assert property ($rose(resetn) |->
      (fast_port_request_to_send_n && console_port_request_to_send_n) [*2])
      else $error("request to send active after reset");
   write_answer_a: assert property (axi_req.awvalid &&
      axi_rsp.awready && axi_req.wvalid && axi_rsp.wready |-> ##[1:2]
      axi_rsp.bvalid) else $error("write answer late");
   read_answer_a: assert property (axi_req.arvalid && axi_rsp.arready
      |-> ##[1:3] axi_rsp.rvalid) else $error("read answer late");
   write_done_a: assert property (axi_rsp.bvalid && axi_req.bready
      |=> !axi_rsp.bvalid) else $error("write answer not released");
   read_done_a: assert property (axi_rsp.rvalid && axi_req.rready
      |=> !axi_rsp.rvalid) else $error("read answer not released");
   write_block_a: assert property (axi_rsp.bvalid |->
      !axi_rsp.awready && !axi_rsp.wready) else $error("write taken early");
   read_block_a: assert property (axi_rsp.rvalid |->
      !axi_rsp.arready) else $error("read taken early");
   bad_addr_a: assert property (axi_req.arvalid && axi_rsp.arready &&
      axi_req.araddr[7:6] != 2'h0 |-> ##[1:3] axi_rsp.rvalid &&
      axi_rsp.rresp == RESP_SLVERR) else $error("unmapped read not refused");
endmodule // dual_uart_asserts

// [testbench/modem_model.sv]
// Modem model: handshake and serial frames on one port
`timescale 1ns/1ns
module modem_model (
   input  wire logic sys_clk, // Clock
   input  wire logic rdy,     // Modem ready
   input  wire logic tx,      // From port transmit
   output logic      rx,      // To port receive
   output logic      cts_n    // Clear to send
);
   assign cts_n = !rdy;
   initial rx = 1'b1;
   task automatic recv(input int nb, dv, output logic [11:0] f);
      f = 12'hFFF;
      @(negedge tx);
      repeat (dv / 2) @(posedge sys_clk);
      for (int i = 0; i < nb; i++) begin
         repeat (dv) @(posedge sys_clk);
         f[i] = tx;
      end
   endtask
   task automatic send(input int nb, dv, input logic [11:0] f);
      @(posedge sys_clk);
      rx <= 1'b0;
      for (int i = 0; i < nb; i++) begin
         repeat (dv) @(posedge sys_clk);
         rx <= f[i];
      end
      repeat (dv) @(posedge sys_clk);
      rx <= 1'b1;
   endtask
endmodule // modem_model

// [testbench/dual_uart_tb_top.sv]
// Self-checking bench for the dual serial port block
`timescale 1ns/1ns
module dual_uart_tb_top;
   import uart_pkg::*;
   logic sys_clk = 1'b0, resetn = 1'b0, strap = 1'b1, sel = 1'b0, rdy = 1'b0;
   axil_req_s req = '0;
   axil_rsp_s rsp, rs;
   logic tx0, tx1, rts0, rts1, mrx, mcts;
   int miscompares = 0, checks_done = 0;
   always #50 sys_clk = ~sys_clk;
   always @(negedge sys_clk) rs <= rsp;
   dual_uart i_dual_uart (.sys_clk, .resetn, .axi_req(req), .axi_rsp(rsp),
      .megabaud_strap(strap), .fast_port_serial_in(sel | mrx),
      .fast_port_serial_out(tx0), .fast_port_clear_to_send_n(sel | mcts),
      .fast_port_request_to_send_n(rts0), .console_port_serial_in(!sel | mrx),
      .console_port_serial_out(tx1),
      .console_port_clear_to_send_n(!sel | mcts),
      .console_port_request_to_send_n(rts1));
   modem_model i_modem_model (.sys_clk, .rdy, .tx(sel ? tx1 : tx0), .rx(mrx),
      .cts_n(mcts));
   task automatic cmp(input string n, input logic [31:0] e, s);
      checks_done++;
      if (s !== e) begin
         miscompares++;
         $display("MISMATCH %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      req.awvalid <= 1'b1;
      req.awaddr <= a;
      req.wvalid <= 1'b1;
      req.wdata <= d;
      req.wstrb <= 4'hF;
      req.bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (rs.awready) req.awvalid <= 1'b0;
         if (rs.wready) req.wvalid <= 1'b0;
      end while (!rs.bvalid);
      req.bready <= 1'b0;
      cmp("bresp", RESP_OKAY, rs.bresp);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      @(posedge sys_clk);
      req.arvalid <= 1'b1;
      req.araddr <= a;
      req.rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (rs.arready) req.arvalid <= 1'b0;
      end while (!rs.rvalid);
      d = rs.rdata;
      r = rs.rresp;
      req.rready <= 1'b0;
   endtask
   function automatic logic [11:0] frm(input logic [7:0] d, lc, output int nb);
      logic [11:0] f;
      f = 12'hFFF;
      nb = 5 + lc[1:0];
      for (int k = 0; k < nb; k++) f[k] = d[k];
      if (lc[LC_PAR_EN]) begin
         f[nb] = ^(d & 8'((16'h1 << nb) - 16'h1)) ~^ lc[LC_PAR_EVEN];
         nb++;
      end
      nb += 1 + lc[LC_STOP2];
      return f;
   endfunction
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      logic [31:0] d, v;
      logic [7:0] lc, b;
      logic [11:0] f, g;
      logic [1:0] r;
      int nb, dv;
      void'($urandom(35));
      repeat (20) @(posedge sys_clk);
      resetn <= 1'b1;
      repeat (4) @(posedge sys_clk);
      rd(8'h0C, v, r);
      cmp("strap", 1, v[ST_STRAP]);
      rd(8'h40, v, r);
      cmp("slverr", RESP_SLVERR, r);
      for (int i = 0; i < 24; i++) begin
         sel <= i >= 12;
         rdy <= 1'($urandom);
         b = (i >= 12) ? PORT_STRIDE : 8'h00;
         dv = (i % 4 == 0) ? DIV_FASTEST : 12 + $urandom % 30;
         lc = {i == 7, 1'($urandom), i % 12 == 5, i % 3 == 2, i % 3 != 0,
               1'($urandom), 2'(i % 4)};
         d = $urandom;
         wr(b + 8'h08, 32'(dv));
         wr(b + 8'h04, {24'h0, lc});
         cmp("rts", lc[5] | !lc[6], sel ? rts1 : rts0);
         if (lc[7]) dv = DIV_MBAUD_HI;
         f = frm(d[7:0], lc, nb);
         if (lc[5]) begin
            wr(b, d);
            repeat (nb * dv + 40) @(posedge sys_clk);
            cmp("tx", 1, sel ? tx1 : tx0);
         end else begin
            fork
               i_modem_model.recv(nb, dv, g);
               wr(b, d);
            join
            cmp("frame", f, g);
            if (i == 10) f[7] = !f[7]; // Corner: bad parity
            i_modem_model.send(nb, dv, f);
            repeat (4) @(posedge sys_clk);
         end
         rd(b, v, r);
         cmp("data", d & ((32'h1 << (5 + lc[1:0])) - 1), v);
         rd(b + 8'h0C, v, r);
         cmp("status", {2'h0, i == 10, rdy}, v[6:3]);
         if (i == 10) wr(b + 8'h0C, 32'h70);
         $display("test %0d done", i);
      end
      strap <= 1'b0;
      resetn <= 1'b0;
      repeat (20) @(posedge sys_clk);
      resetn <= 1'b1;
      sel <= 1'b0;
      repeat (4) @(posedge sys_clk);
      rd(8'h0C, v, r);
      cmp("strap", 0, v[ST_STRAP]);
      wr(8'h04, 32'h83);
      f = frm(8'h5A, 8'h83, nb);
      fork
         i_modem_model.recv(nb, DIV_MBAUD_LO, g);
         wr(8'h00, 32'h5A);
      join
      cmp("slow frame", f, g);
      $display("test strap done");
      close_out;
   end
   initial begin
      repeat (90000) @(posedge sys_clk);
      miscompares++;
      close_out;
   end
endmodule // dual_uart_tb_top
bind dual_uart dual_uart_asserts i_dual_uart_asserts (.sys_clk, .resetn,
   .axi_req, .axi_rsp, .fast_port_serial_out, .fast_port_request_to_send_n,
   .console_port_serial_out, .console_port_request_to_send_n);
